// [src/dpsem_host.sv]
// Purpose: drives one port of a dual-port semaphore device through its pins
// Assumes: pins are asynchronous to i_clk_sys; device holds no reset
// Notes:   frees all eight flags after reset before accepting commands
// How it works
// - system allows exactly one master part
// - hold address, enable until busy settles, then write
// - ram enable high while semaphore select low
// - poller drops enable between reads
// - claim writes zero first, then reads back
// - failed claim polls or withdraws with one
// - software writes one to every flag first
`timescale 1ns/100ps
`default_nettype none
module dpsem_host import dpsem_pkg::*; #(
	parameter logic IS_MASTER = 1'h0  // level driven on the mode pin
) (
	input  wire logic               i_clk_sys,
	input  wire logic               i_reset_n,
	input  wire logic               i_cmd_valid,  // request, taken when ready
	input  wire dpsem_op_t          i_cmd_op,     // read, claim or release
	input  wire logic [INDEX_W-1:0] i_cmd_index,  // flag number
	input  wire logic               i_cmd_wait,   // claim keeps polling
	output logic                    o_ready,      // idle, takes a command
	output logic                    o_done,       // one-cycle completion
	output logic                    o_granted,    // this port holds flag
	output logic [DATA_W-1:0]       o_rd_data,    // last captured read
	output logic                    o_master_sel, // mode pin
	output logic                    o_ce_n,       // ram enable pin
	output logic                    o_sem_sel_n,  // semaphore select pin
	output logic                    o_oe_n,       // output enable pin
	output logic                    o_rw_n,       // write strobe, low writes
	output logic [INDEX_W-1:0]      o_flag_index_bits, // low address pins
	output logic [DATA_W-1:0]       o_data,       // data pins, out value
	output logic                    o_data_oe_n,  // low while driving data
	input  wire logic [DATA_W-1:0]  i_data,       // data pins, in value
	input  wire logic               i_busy_n      // busy pin of this port
);
	typedef enum logic [2:0] {
		S_BOOT, S_IDLE, S_W_SETUP, S_W_PULSE, S_W_HOLD, S_R_ACCESS, S_R_GAP
	} dpsem_state_t;

	dpsem_state_t       state_q, state_d;  // sequencer state
	logic [CNT_W-1:0]   cnt_q, cnt_d;      // cycles left in state
	logic [INDEX_W-1:0] idx_q, idx_d;      // flag being worked on
	logic               wbit_q, wbit_d;    // level written on bit 0
	dpsem_op_t          op_q, op_d;        // command in progress
	logic               wait_q, wait_d;    // polling claim
	logic               init_q, init_d;    // power-up sweep running
	logic               wrote_q, wrote_d;  // a write done this command
	logic [DATA_W-1:0]  rd_q, rd_d;        // captured read value
	logic               gnt_q, gnt_d;      // ownership seen
	logic               done_d;            // completion pulse next
	logic [DATA_W-1:0]  data_sync;         // synchronised data pins
	logic               busy_sync;         // synchronised busy pin

	// pins cross two flops before use
	dpsem_sync #(.W(DATA_W + 1)) u_sync (
		.i_clk_sys (i_clk_sys),
		.i_reset_n (i_reset_n),
		.i_d       ({i_busy_n, i_data}),
		.o_q       ({busy_sync, data_sync})
	);

	// converts a duration into a starting count
	function automatic logic [CNT_W-1:0] load(input int n);
		return CNT_W'(n - 1);
	endfunction : load

	// sequencer next state
	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_q;
		idx_d   = idx_q;
		wbit_d  = wbit_q;
		op_d    = op_q;
		wait_d  = wait_q;
		init_d  = init_q;
		wrote_d = wrote_q;
		rd_d    = rd_q;
		gnt_d   = gnt_q;
		done_d  = 1'b0;
		case (state_q)
			S_BOOT: begin
				// latches start unknown, free every flag
				init_d  = 1'b1;
				idx_d   = '0;
				wbit_d  = FLAG_FREE;
				state_d = S_W_SETUP;
				cnt_d   = load(SETUP_CNT);
			end
			S_IDLE: if (i_cmd_valid) begin
				op_d    = i_cmd_op;
				idx_d   = i_cmd_index;
				wait_d  = i_cmd_wait;
				wrote_d = 1'b0;
				if (i_cmd_op == OP_READ) begin
					state_d = S_R_ACCESS;
					cnt_d   = load(ACCESS_CNT);
				end else begin
					// claim writes zero first, release writes one
					wbit_d  = (i_cmd_op == OP_RELEASE);
					state_d = S_W_SETUP;
					cnt_d   = load(SETUP_CNT);
				end
			end
			S_W_SETUP: begin
				// strobe only after settle time and busy seen high
				if (cnt_q != '0) begin
					cnt_d = cnt_q - 1'b1;
				end else if (busy_sync) begin
					state_d = S_W_PULSE;
					cnt_d   = load(WPULSE_CNT);
				end
			end
			S_W_PULSE: begin
				if (cnt_q != '0) begin
					cnt_d = cnt_q - 1'b1;
				end else begin
					state_d = S_W_HOLD;
					cnt_d   = load(HOLD_CNT);
				end
			end
			S_W_HOLD: begin
				if (cnt_q != '0) begin
					cnt_d = cnt_q - 1'b1;
				end else begin
					wrote_d = 1'b1;
					if (init_q) begin
						// sweep to the last flag
						if (idx_q == FLAG_LAST) begin
							init_d  = 1'b0;
							state_d = S_IDLE;
						end else begin
							idx_d   = idx_q + 1'b1;
							state_d = S_W_SETUP;
							cnt_d   = load(SETUP_CNT);
						end
					end else if (op_q == OP_CLAIM && wbit_q == FLAG_OWNED) begin
						// read back to confirm the claim
						state_d = S_R_ACCESS;
						cnt_d   = load(ACCESS_CNT);
					end else begin
						// release or withdrawal finished
						gnt_d   = 1'b0;
						done_d  = 1'b1;
						state_d = S_IDLE;
					end
				end
			end
			S_R_ACCESS: begin
				if (cnt_q != '0) begin
					cnt_d = cnt_q - 1'b1;
				end else begin
					rd_d    = data_sync;
					state_d = S_R_GAP;
					cnt_d   = load(GAP_CNT);
				end
			end
			S_R_GAP: begin
				// select and enable stay inactive here
				if (cnt_q != '0) begin
					cnt_d = cnt_q - 1'b1;
				end else if (op_q != OP_CLAIM) begin
					gnt_d   = (rd_q[FLAG_BIT] == FLAG_OWNED);
					done_d  = 1'b1;
					state_d = S_IDLE;
				end else if (rd_q[FLAG_BIT] == FLAG_OWNED) begin
					gnt_d   = 1'b1;
					done_d  = 1'b1;
					state_d = S_IDLE;
				end else if (wait_q) begin
					// keep polling until ownership
					state_d = S_R_ACCESS;
					cnt_d   = load(ACCESS_CNT);
				end else begin
					// withdraw the pending request
					wbit_d  = FLAG_FREE;
					state_d = S_W_SETUP;
					cnt_d   = load(SETUP_CNT);
				end
			end
			default: state_d = S_IDLE;
		endcase
	end

	// sequencer registers
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state_q <= S_BOOT;
			cnt_q   <= '0;
			idx_q   <= '0;
			wbit_q  <= FLAG_FREE;
			op_q    <= OP_READ;
			wait_q  <= 1'b0;
			init_q  <= 1'b0;
			wrote_q <= 1'b0;
			rd_q    <= '1;
			gnt_q   <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
			idx_q   <= idx_d;
			wbit_q  <= wbit_d;
			op_q    <= op_d;
			wait_q  <= wait_d;
			init_q  <= init_d;
			wrote_q <= wrote_d;
			rd_q    <= rd_d;
			gnt_q   <= gnt_d;
		end
	end

	logic in_write_d;  // next state is a write phase
	logic sem_n_d, oe_n_d, rw_n_d;

	// pin levels follow the next state
	always_comb begin
		in_write_d = (state_d == S_W_SETUP) || (state_d == S_W_PULSE) ||
			(state_d == S_W_HOLD);
		sem_n_d    = !(in_write_d || state_d == S_R_ACCESS);
		oe_n_d     = (state_d != S_R_ACCESS);
		rw_n_d     = (state_d != S_W_PULSE);
	end

	// output pins and user status, all from flops
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_ready           <= 1'b0;
			o_done            <= 1'b0;
			o_granted         <= 1'b0;
			o_rd_data         <= '1;
			o_master_sel      <= 1'b0;
			o_ce_n            <= 1'b1;
			o_sem_sel_n       <= 1'b1;
			o_oe_n            <= 1'b1;
			o_rw_n            <= 1'b1;
			o_flag_index_bits <= '0;
			o_data            <= '1;
			o_data_oe_n       <= 1'b1;
		end else begin
			o_ready           <= (state_d == S_IDLE);
			o_done            <= done_d;
			o_granted         <= gnt_d;
			o_rd_data         <= rd_d;
			o_master_sel      <= IS_MASTER;
			o_ce_n            <= 1'b1;
			o_sem_sel_n       <= sem_n_d;
			o_oe_n            <= oe_n_d;
			o_rw_n            <= rw_n_d;
			o_flag_index_bits <= idx_d;
			o_data            <= {DATA_W{wbit_d}};
			o_data_oe_n       <= !in_write_d;
		end
	end

	// helper logic for the checks below
	logic [CNT_W-1:0] settle_q;   // cycles select low with strobe high
	logic [CNT_W-1:0] boot_wr_q;  // write strobes before first ready
	logic             booting_q;  // no ready seen yet
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			settle_q  <= '0;
			boot_wr_q <= '0;
			booting_q <= 1'b1;
		end else begin
			settle_q  <= (!o_sem_sel_n && o_rw_n) ?
				((settle_q == '1) ? settle_q : settle_q + 1'b1) : '0;
			boot_wr_q <= (booting_q && $rose(o_rw_n)) ?
				boot_wr_q + 1'b1 : boot_wr_q;
			booting_q <= booting_q && !o_ready;
		end
	end

	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_reset_n);

	property p_one_master;
		o_ready |-> o_master_sel == IS_MASTER;
	endproperty
	a_one_master: assert property (p_one_master)
		else $error("mode pin differs from configured master setting");

	property p_setup_before_strobe;
		$fell(o_rw_n) |-> settle_q >= CNT_W'(SETUP_CNT) && !o_sem_sel_n;
	endproperty
	a_setup_before_strobe: assert property (p_setup_before_strobe)
		else $error("write strobe started before address settled");

	property p_ce_off;
		!o_sem_sel_n |-> o_ce_n;
	endproperty
	a_ce_off: assert property (p_ce_off)
		else $error("ram enable active during semaphore access");

	property p_read_gap;
		$rose(o_oe_n) |-> (o_oe_n && o_sem_sel_n) [*2];
	endproperty
	a_read_gap: assert property (p_read_gap)
		else $error("read gap shorter than two cycles");

	property p_write_then_read;
		$fell(o_oe_n) && op_q == OP_CLAIM |-> wrote_q;
	endproperty
	a_write_then_read: assert property (p_write_then_read)
		else $error("claim read before its write");

	property p_withdraw;
		o_done && op_q == OP_CLAIM && !o_granted |->
			wbit_q == FLAG_FREE && $past(o_data_oe_n, 2) == 1'b0;
	endproperty
	a_withdraw: assert property (p_withdraw)
		else $error("failed claim ended without writing one");

	property p_boot_sweep;
		$rose(o_ready) && booting_q |-> boot_wr_q == CNT_W'(FLAG_COUNT);
	endproperty
	a_boot_sweep: assert property (p_boot_sweep)
		else $error("ready before all eight flags were freed");

endmodule : dpsem_host
`default_nettype wire

// [src/dpsem_pkg.sv]
// Purpose: shared constants and types for the semaphore port controller
// Assumes: one 100 MHz system clock
// Notes:   all pin timing is held as a time plus a derived cycle count
package dpsem_pkg;

	// clock period of i_clk_sys
	localparam int CLK_PERIOD_NS = 10;

	// rounds a least time up to whole cycles, never below one
	function automatic int dpsem_min_cycles(input int t_ns);
		int c;
		c = (t_ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction : dpsem_min_cycles

	// address and select settle time before the write strobe
	localparam int T_SETUP_NS  = 30;
	// write strobe width
	localparam int T_WPULSE_NS = 20;
	// hold after strobe release
	localparam int T_HOLD_NS   = 10;
	// read access time after select and output enable go active
	localparam int T_ACCESS_NS = 30;
	// inactive gap between two reads so the output latch reloads
	localparam int T_GAP_NS    = 20;
	// stages of the pin synchroniser
	localparam int SYNC_STAGES = 2;

	localparam int SETUP_CNT  = dpsem_min_cycles(T_SETUP_NS);
	localparam int WPULSE_CNT = dpsem_min_cycles(T_WPULSE_NS);
	localparam int HOLD_CNT   = dpsem_min_cycles(T_HOLD_NS);
	localparam int ACCESS_CNT = dpsem_min_cycles(T_ACCESS_NS) + SYNC_STAGES;
	localparam int GAP_CNT    = dpsem_min_cycles(T_GAP_NS);

	// widths and layout of the semaphore space
	localparam int DATA_W     = 8;
	localparam int INDEX_W    = 3;
	localparam int CNT_W      = 4;
	localparam int FLAG_COUNT = 8;
	localparam logic [INDEX_W-1:0] FLAG_LAST  = 3'h7;
	localparam int FLAG_BIT   = 0;
	// flag level seen by the owning port
	localparam logic FLAG_OWNED = 1'h0;
	localparam logic FLAG_FREE  = 1'h1;

	// commands a user may ask for
	typedef enum logic [1:0] {
		OP_READ,
		OP_CLAIM,
		OP_RELEASE
	} dpsem_op_t;

endpackage : dpsem_pkg

// [src/dpsem_sync.sv]
// Purpose: two-stage synchroniser for pins from outside the clock domain
// Assumes: i_d changes slowly compared with the clock
// Notes:   only the second stage is visible outside
`timescale 1ns/100ps
`default_nettype none
module dpsem_sync #(
	parameter int W = 1
) (
	input  wire logic         i_clk_sys,
	input  wire logic         i_reset_n,
	input  wire logic [W-1:0] i_d,
	output logic      [W-1:0] o_q
);
	logic [W-1:0] meta_q;  // first stage, read only by second stage

	// two flops in series
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			meta_q <= '1;
			o_q    <= '1;
		end else begin
			meta_q <= i_d;
			o_q    <= meta_q;
		end
	end
endmodule : dpsem_sync
`default_nettype wire

// [tb/dpsem_dev_model.sv]
// Purpose: behavioural dual-port semaphore device, both ports
// Assumes: each port is driven by one host controller
// Notes: latches start unknown, no reset input
`timescale 1ns/100ps
`default_nettype none
module dpsem_dev_model (
	input  wire logic [1:0] i_ce_n,    // ram enables
	input  wire logic [1:0] i_sem_n,   // semaphore selects
	input  wire logic [1:0] i_oe_n,    // output enables
	input  wire logic [1:0] i_rw_n,    // write strobes
	input  wire logic [1:0] i_doe_n,   // host drives data when low
	input  wire logic [2:0] i_idx [2], // flag index pins per port
	input  wire logic [7:0] i_d [2],   // host data per port
	input  wire logic [1:0] i_ms,      // mode pin per port
	input  wire logic [1:0] i_busy_n,  // busy level at each port
	output logic      [1:0] o_busy_n,  // busy from a master part
	output logic      [7:0] o_q [2],   // wire level seen by host
	output logic            o_viol     // pin protocol broken
);
	logic [7:0] req_q [2]; // request latches, low requests
	logic [1:0] own [8];   // 0 free, 1 port 0, 2 port 1

	initial o_viol = 1'b0;

	// first zero wins; a release hands over a pending request
	function automatic logic [1:0] pick(logic [1:0] o, logic a, logic b);
		if (o === 2'h1 && a === 1'b0) return o;
		if (o === 2'h2 && b === 1'b0) return o;
		if (a === 1'b0) return 2'h1;
		if (b === 1'b0) return 2'h2;
		if (a === 1'b1 && b === 1'b1) return 2'h0;
		return 2'hx;
	endfunction : pick

	// ports act alone, flags gate nothing
	for (genvar p = 0; p < 2; p++) begin : g_port
		logic [2:0] wix; // index held at strobe start
		logic       act; // read cycle active
		logic [7:0] cap; // frozen read value
		logic       inh; // write blocked by busy
		// mode high: busy is an output, decided on enables and
		// index only, port 1 taken as the later one
		assign o_busy_n[p] = !(i_ms[p] && p == 1 && !i_ce_n[0] &&
			!i_ce_n[1] && i_idx[0] == i_idx[1]);
		assign act = !i_sem_n[p] && !i_oe_n[p] && i_ce_n[p];
		// host drive, else captured flag, else its inverse when idle
		assign o_q[p] = !i_doe_n[p] ? i_d[p] : act ? cap : ~cap;
		initial cap = 8'h5a;
		// capture when select and enable meet
		always @(posedge act) begin
			// let the pins of the same clock edge settle first
			#1;
			cap = (own[i_idx[p]] === 2'(p + 1)) ? 8'h00 : 8'hff;
			if (!i_doe_n[p]) o_viol = 1'b1;
		end
		// strobe start needs ram enable off and data driven
		always @(negedge i_rw_n[p]) begin
			wix = i_idx[p];
			// busy low blocks the write and flags a violation
			inh = (i_busy_n[p] !== 1'b1);
			if (i_sem_n[p] !== 1'b0 || !i_ce_n[p] || i_doe_n[p] || inh)
				o_viol = 1'b1;
		end
		// write lands at strobe end, bit 0 only
		always @(posedge i_rw_n[p]) begin
			if (i_sem_n[p] === 1'b0 && !inh) begin
				if (wix !== i_idx[p]) o_viol = 1'b1;
				req_q[p][wix] = i_d[p][0];
				own[wix] = pick(own[wix], req_q[0][wix], req_q[1][wix]);
			end
		end
	end
endmodule : dpsem_dev_model
`default_nettype wire

// [tb/testbench.sv]
// Purpose: two host ports against one semaphore device model
// Assumes: port 0 host is the master part, port 1 a slave
// Notes:   every wait is bounded
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import dpsem_pkg::*;
	logic               clk_sys;
	logic               reset_n;
	logic [1:0]         cv, cw, bsy_n, rdy, dn, gr, ms;
	logic [1:0]         ce_n, sem_n, oe_n, rw_n, doe_n;
	logic [1:0]         mbsy, hb_n;
	dpsem_op_t          cop [2];
	logic [INDEX_W-1:0] cix [2];
	logic [INDEX_W-1:0] ix [2];
	logic [DATA_W-1:0]  rd [2];
	logic [DATA_W-1:0]  dq [2];
	logic [DATA_W-1:0]  dd [2];
	logic               viol, g, g2;
	logic [DATA_W-1:0]  r, r2;
	int                 n_fail;
	int                 n_tests;

	// one host per port
	for (genvar s = 0; s < 2; s++) begin : g_host
		dpsem_host #(.IS_MASTER(1'(s == 0))) dut (
			.i_clk_sys(clk_sys), .i_reset_n(reset_n),
			.i_cmd_valid(cv[s]), .i_cmd_op(cop[s]),
			.i_cmd_index(cix[s]), .i_cmd_wait(cw[s]),
			.o_ready(rdy[s]), .o_done(dn[s]), .o_granted(gr[s]),
			.o_rd_data(rd[s]), .o_master_sel(ms[s]), .o_ce_n(ce_n[s]),
			.o_sem_sel_n(sem_n[s]), .o_oe_n(oe_n[s]), .o_rw_n(rw_n[s]),
			.o_flag_index_bits(ix[s]), .o_data(dd[s]),
			.o_data_oe_n(doe_n[s]), .i_data(dq[s]), .i_busy_n(hb_n[s])
		);
	end

	// busy seen by each host: master output and bench stall together
	assign hb_n = bsy_n & mbsy;

	dpsem_dev_model model (
		.i_ce_n(ce_n), .i_sem_n(sem_n), .i_oe_n(oe_n), .i_rw_n(rw_n),
		.i_doe_n(doe_n), .i_idx(ix), .i_d(dd), .o_q(dq), .o_viol(viol),
		.i_ms(ms), .i_busy_n(hb_n), .o_busy_n(mbsy)
	);

	always #5 clk_sys = ~clk_sys;

	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : stop_test

	task automatic check(input string nm, input logic [7:0] seen, exp);
		n_tests++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	// a wait that ran out ends the run
	task automatic bail(input string nm);
		n_fail++;
		$display("Error %s expected done seen timeout", nm);
		stop_test();
	endtask : bail

	// one command on port s, result taken at done
	task automatic cmd(input int s, input dpsem_op_t op, input int i, wt,
			output logic gv, output logic [7:0] rv);
		int k;
		@(posedge clk_sys);
		cv[s] <= 1'b1;
		cop[s] <= op;
		cix[s] <= 3'(i);
		cw[s] <= 1'(wt);
		for (k = 0; k < 3000 && rdy[s] !== 1'b1; k++) @(negedge clk_sys);
		if (k == 3000) bail("cmd_ready");
		@(posedge clk_sys);
		cv[s] <= 1'b0;
		for (k = 0; k < 3000 && dn[s] !== 1'b1; k++) @(negedge clk_sys);
		if (k == 3000) bail("cmd_done");
		gv = gr[s];
		rv = rd[s];
	endtask : cmd

	// boot sweep frees every flag; pin modes after reset
	task automatic t_boot();
		int k;
		for (k = 0; k < 500 && rdy !== 2'h3; k++) @(negedge clk_sys);
		if (k == 500) bail("boot_ready");
		check("master_sel", ms, 2'h1);
		check("ce_n", ce_n, 2'h3);
		for (int i = 0; i < 8; i++) begin
			cmd(1, OP_READ, i, 0, g, r);
			check("boot_flag", r, 8'hff);
		end
	endtask : t_boot

	// claim, refused claim with withdraw, release, on every flag
	task automatic t_claim();
		for (int i = 0; i < 8; i++) begin
			cmd(0, OP_CLAIM, i, 0, g, r);
			check("claim_a", g, 1'b1);
			check("read_a", r, 8'h00);
			cmd(0, OP_READ, 7 - i, 0, g, r);
			check("other_a", r, 8'hff);
			check("other_own", g, 1'b0);
			cmd(1, OP_CLAIM, i, 0, g, r);
			check("claim_b", g, 1'b0);
			check("read_b", r, 8'hff);
			cmd(0, OP_RELEASE, i, 0, g, r);
			check("rel_a", g, 1'b0);
			cmd(1, OP_READ, i, 0, g, r);
			check("free_b", r, 8'hff);
		end
	endtask : t_claim

	// polling claim wins once the owner lets go
	task automatic t_pass();
		cmd(0, OP_CLAIM, 6, 0, g, r);
		fork
			cmd(1, OP_CLAIM, 6, 1, g, r);
			begin
				repeat (80) @(negedge clk_sys);
				cmd(0, OP_RELEASE, 6, 0, g2, r2);
			end
		join
		check("poll_b", g, 1'b1);
		cmd(1, OP_RELEASE, 6, 0, g, r);
		cmd(0, OP_READ, 6, 0, g, r);
		check("poll_free", r, 8'hff);
	endtask : t_pass

	// busy low holds the write strobe back
	task automatic t_busy();
		@(posedge clk_sys);
		bsy_n[0] <= 1'b0;
		fork
			cmd(0, OP_RELEASE, 2, 0, g, r);
			begin
				repeat (40) begin
					@(negedge clk_sys);
					check("rw_held", rw_n[0], 1'b1);
				end
				check("sem_held", sem_n[0], 1'b0);
				@(posedge clk_sys);
				bsy_n[0] <= 1'b1;
			end
		join
		check("busy_rel", g, 1'b0);
	endtask : t_busy

	initial begin
		clk_sys = 1'b0;
		reset_n = 1'b0;
		cv = 2'h0;
		cw = 2'h0;
		bsy_n = 2'h3;
		cop[0] = OP_READ;
		cop[1] = OP_READ;
		cix[0] = 3'h0;
		cix[1] = 3'h0;
		n_fail = 0;
		n_tests = 0;
		repeat (12) @(posedge clk_sys);
		reset_n <= 1'b1;
		t_boot();
		t_claim();
		t_pass();
		t_busy();
		check("pin_protocol", viol, 1'b0);
		stop_test();
	end
endmodule : testbench
`default_nettype wire
